// [frt_timer.sv]
// Free-running 16-bit timer with prescaler, input capture and port A sharing.
// Assumes control bits arrive as plain ports from a register block on I_CORE_CLK.
// Contract
// - Prescaler divides bus cycles (two core clocks each) by 1, 4, 8 or 16 for select 00..11.
// - Sixteen-bit up-counter starts at zero after reset, counts each tick.
// - At all-ones the counter wraps to zero, sets overflow, keeps running.
// - Software cannot reset, load or stop the counter.
// - Three capture, four compare, one switchable capture/compare channel.
// - Each capture and compare channel owns a 16-bit register.
// - Every timer function has its own enable and own request line.
// - Selected pin edge latches the counter into that channel's register.
// - Edges are synchronised; latch on the half opposite to incrementing.
// - Low four port A pin levels stay readable even during capture.
// - Port data writes do not drive a pin used for compare output.
// - First compare channel may drive any mix of pins 7 to 3.
// - Pin 3 is fifth compare after reset; select bit makes it capture.
// - Output pin 3 with fourth capture on: data writes cause captures.
// - Writes to the shared register are ignored while it captures.
// - Edge select 00 off, 01 rising, 10 falling, 11 either; reset off.
// - High-byte read blocks capture while it is asserted; the capture is delayed.
// - Channels work independently and may latch the same count.
`timescale 1ns/1ps
`default_nettype none
module frt_timer
   import frt_pkg::*;
#(
   parameter int W = FRT_CNT_W
) (
   // Clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_RST,
   // Configuration
   input wire logic [1:0] I_PRESCALE_SELECT,
   input wire frt_edge_cfg_t I_EDGE_CFG,
   input wire logic I_CAPTURE4_SELECT,
   input wire logic I_SHARED_PIN_DIRECTION,
   input wire logic [7:3] I_FIRST_COMPARE_PIN_MASK,
   input wire logic [7:3] I_FIRST_COMPARE_PIN_LEVEL,
   input wire logic [FRT_NUM_CAP-1:0] I_CAP_IRQ_ENABLE,
   input wire logic [FRT_NUM_CMP-1:0] I_CMP_IRQ_ENABLE,
   input wire logic I_OVF_IRQ_ENABLE,
   // Flag clears, one bit per flag
   input wire logic [FRT_NUM_CAP-1:0] I_CAP_FLAG_CLEAR,
   input wire logic [FRT_NUM_CMP-1:0] I_CMP_FLAG_CLEAR,
   input wire logic I_OVF_FLAG_CLEAR,
   // Compare register writes and compare events from the compare logic
   input wire logic [FRT_NUM_CMP-1:0] I_CMP_WRITE,
   input wire logic [W-1:0] I_CMP_WDATA,
   input wire logic [FRT_NUM_CMP-1:0] I_CMP_MATCH_EVENT,
   input wire logic [FRT_NUM_CMP-1:0] I_CMP_PIN_LEVEL,
   // High-byte reads of the capture registers
   input wire logic [FRT_NUM_CAP-1:0] I_CAP_HIGH_READ,
   // Port A
   input wire logic [7:0] I_PORT_A_PIN,
   input wire logic [7:0] I_PORT_A_DATA_WRITE,
   input wire logic [7:0] I_PORT_A_DATA_WSTB,
   // Counter, captures and compare registers
   output logic [W-1:0] O_FREE_RUNNING_COUNT,
   output logic [FRT_NUM_CAP-1:0][W-1:0] O_CAPTURE,
   output logic [FRT_NUM_CMP-1:0][W-1:0] O_COMPARE,
   // Flags and request lines
   output logic [FRT_NUM_CAP-1:0] O_CAP_FLAG,
   output logic [FRT_NUM_CMP-1:0] O_CMP_FLAG,
   output logic O_OVF_FLAG,
   output logic [FRT_NUM_CAP-1:0] O_CAP_IRQ,
   output logic [FRT_NUM_CMP-1:0] O_CMP_IRQ,
   output logic O_OVF_IRQ,
   // Port A data and outputs
   output logic [7:0] O_PORT_A_DATA_REG,
   output logic [7:3] O_PORT_A_OUT,
   output logic [7:3] O_PORT_A_OE
);
   logic [3:0] prescale;
   logic [3:0] div_last;
   logic tick;
   frt_phase_t phase;
   logic [W-1:0] count;
   logic [7:0] pin_meta;
   logic [7:0] pin_sync;
   logic [7:0] port_latch;
   logic [3:0] cap_pin;
   logic [3:0] cap_enable;
   logic [FRT_NUM_CAP-1:0] cap_event;
   logic [FRT_NUM_CAP-1:0][W-1:0] cap_value;
   logic [FRT_NUM_CAP-1:0][1:0] edge_sel;
   logic [FRT_NUM_CMP-1:0] cmp_write_ok;
   logic [7:3] next_out;
   logic [7:3] cmp_owned;

   function automatic logic [3:0] div_limit(input logic [1:0] sel);
      case (sel)
         2'h0: div_limit = FRT_DIV_BY_1;
         2'h1: div_limit = FRT_DIV_BY_4;
         2'h2: div_limit = FRT_DIV_BY_8;
         default: div_limit = FRT_DIV_BY_16;
      endcase
   endfunction

   assign div_last = div_limit(I_PRESCALE_SELECT);
   assign tick = (prescale >= div_last) && (phase == FRT_PHASE_TWO);

   // Core clock is split into two phases: count on phase two, capture on phase one
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         phase <= FRT_PHASE_ONE;
      end else begin
         phase <= (phase == FRT_PHASE_ONE) ? FRT_PHASE_TWO : FRT_PHASE_ONE;
      end
   end

   // Prescaler counts bus cycles (one per phase pair)
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         prescale <= 4'h0;
      end else if (phase == FRT_PHASE_TWO) begin
         prescale <= (prescale >= div_last) ? 4'h0 : prescale + 4'h1;
      end
   end

   // No load, clear or stop input exists for the counter
   // The add wraps from all ones to zero by itself; the overflow flag is set below
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         count <= W'(FRT_CNT_RESET);
      end else if (tick) begin
         count <= count + W'(1);
      end
   end

   assign O_FREE_RUNNING_COUNT = count;

   // Overflow flag, set wins over clear
   // All ones is cut to the counter width so narrower builds also flag the wrap
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_OVF_FLAG <= 1'b0;
      end else if (tick && count == W'(FRT_CNT_MAX)) begin
         O_OVF_FLAG <= 1'b1;
      end else if (I_OVF_FLAG_CLEAR) begin
         O_OVF_FLAG <= 1'b0;
      end
   end

   // Pin synchroniser
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         pin_meta <= 8'h00;
         pin_sync <= 8'h00;
      end else begin
         pin_meta <= I_PORT_A_PIN;
         pin_sync <= pin_meta;
      end
   end

   // Port data latch for software writes
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         port_latch <= 8'h00;
      end else begin
         for (int b = 0; b < 8; b++) begin
            if (I_PORT_A_DATA_WSTB[b]) begin
               port_latch[b] <= I_PORT_A_DATA_WRITE[b];
            end
         end
      end
   end

   // Read view: low four bits are always the pin levels
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_PORT_A_DATA_REG <= 8'h00;
      end else begin
         O_PORT_A_DATA_REG <= {port_latch[7:4], pin_sync[3:0]};
      end
   end

   // Channel 3 watches pin 3: as output, the port data latch bit feeds the capture
   // The port latch is already in this clock domain, so it skips the synchroniser
   assign cap_pin = {(I_SHARED_PIN_DIRECTION ? port_latch[FRT_SHARED_PIN]
                      : pin_sync[FRT_SHARED_PIN]), pin_sync[2:0]};
   assign cap_enable = {I_CAPTURE4_SELECT, 3'h7};
   assign edge_sel = I_EDGE_CFG;

   // A high-byte read holds a pending capture back; the edge is delayed, not dropped
   generate
      for (genvar c = 0; c < FRT_NUM_CAP; c++) begin : g_cap
         frt_capture_chan #(.W(W)) u_chan (
            .clk(I_CORE_CLK),
            .rst(I_RST),
            .pin_sync(cap_pin[c]),
            .edge_sel(edge_sel[c]),
            .enable(cap_enable[c]),
            .capture_phase(phase == FRT_PHASE_ONE),
            .hold(I_CAP_HIGH_READ[c]),
            .count(count),
            .capture(cap_value[c]),
            .event_pulse(cap_event[c])
         );
      end
   endgenerate

   assign O_CAPTURE[2:0] = cap_value[2:0];
   assign O_CAPTURE[3] = O_COMPARE[4];

   // Compare registers; the shared one loads captures while in capture mode
   assign cmp_write_ok = I_CMP_WRITE & {~I_CAPTURE4_SELECT, 4'hf};

   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_COMPARE <= '1;
      end else begin
         for (int k = 0; k < FRT_NUM_CMP; k++) begin
            if (cmp_write_ok[k]) begin
               O_COMPARE[k] <= I_CMP_WDATA;
            end
         end
         if (I_CAPTURE4_SELECT && cap_event[3]) begin
            O_COMPARE[4] <= cap_value[3];
         end
      end
   end

   // Flags: set wins over clear
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_CAP_FLAG <= '0;
         O_CMP_FLAG <= '0;
      end else begin
         O_CAP_FLAG <= cap_event | (O_CAP_FLAG & ~I_CAP_FLAG_CLEAR);
         O_CMP_FLAG <= (I_CMP_MATCH_EVENT & {~I_CAPTURE4_SELECT, 4'hf})
                       | (O_CMP_FLAG & ~I_CMP_FLAG_CLEAR);
      end
   end

   // Separate request per function
   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_CAP_IRQ <= '0;
         O_CMP_IRQ <= '0;
         O_OVF_IRQ <= 1'b0;
      end else begin
         O_CAP_IRQ <= O_CAP_FLAG & I_CAP_IRQ_ENABLE;
         O_CMP_IRQ <= O_CMP_FLAG & I_CMP_IRQ_ENABLE;
         O_OVF_IRQ <= O_OVF_FLAG & I_OVF_IRQ_ENABLE;
      end
   end

   // Pin 7..3 driver: compare levels own their pins, first channel may override
   always_comb begin
      cmp_owned = {1'b0, 3'h7, ~I_CAPTURE4_SELECT};
      next_out = port_latch[7:3];
      for (int p = 3; p < 7; p++) begin
         if (cmp_owned[p]) begin
            next_out[p] = I_CMP_PIN_LEVEL[7 - p];
         end
      end
      for (int p = 3; p < 8; p++) begin
         if (I_FIRST_COMPARE_PIN_MASK[p]) begin
            next_out[p] = I_FIRST_COMPARE_PIN_LEVEL[p];
         end
      end
   end

   always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_PORT_A_OUT <= 5'h00;
         O_PORT_A_OE <= 5'h00;
      end else begin
         O_PORT_A_OUT <= next_out;
         O_PORT_A_OE <= {1'b0, 3'h7, ~I_CAPTURE4_SELECT | I_SHARED_PIN_DIRECTION}
                        | I_FIRST_COMPARE_PIN_MASK;
      end
   end
endmodule
`default_nettype wire

// [frt_pkg.sv]
// Package for the free-running timer with input capture.
// Assumes one core clock; all constants used by the timer live here.
package frt_pkg;
   localparam int FRT_CNT_W = 16;
   localparam int FRT_NUM_CAP = 4;
   localparam int FRT_NUM_CMP = 5;
   localparam logic [15:0] FRT_CNT_RESET = 16'h0000;
   localparam logic [15:0] FRT_CNT_MAX = 16'hffff;
   localparam logic [3:0] FRT_DIV_BY_1 = 4'h0;
   localparam logic [3:0] FRT_DIV_BY_4 = 4'h3;
   localparam logic [3:0] FRT_DIV_BY_8 = 4'h7;
   localparam logic [3:0] FRT_DIV_BY_16 = 4'hf;
   localparam logic [1:0] FRT_EDGE_OFF = 2'h0;
   localparam logic [1:0] FRT_EDGE_RISE = 2'h1;
   localparam logic [1:0] FRT_EDGE_FALL = 2'h2;
   localparam logic [1:0] FRT_EDGE_ANY = 2'h3;
   localparam int FRT_SHARED_PIN = 3;
   // Edge selects for the four capture channels
   typedef struct packed {
      logic [1:0] edge_select_high_low_3;
      logic [1:0] edge_select_high_low_2;
      logic [1:0] edge_select_high_low_1;
      logic [1:0] edge_select_high_low_0;
   } frt_edge_cfg_t;
   typedef enum logic [1:0] {FRT_PHASE_ONE, FRT_PHASE_TWO} frt_phase_t;
endpackage

// [frt_capture_chan.sv]
// One input-capture channel: edge detect and latch of the counter value.
// Assumes the pin input is already synchronised to the core clock.
`timescale 1ns/1ps
`default_nettype none
module frt_capture_chan
   import frt_pkg::*;
#(
   parameter int W = FRT_CNT_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic pin_sync,
   input wire logic [1:0] edge_sel,
   input wire logic enable,
   input wire logic capture_phase,
   input wire logic hold,
   input wire logic [W-1:0] count,
   output logic [W-1:0] capture,
   output logic event_pulse
);
   logic pin_prev;
   logic pending;
   logic edge_hit;

   always_comb begin
      case (edge_sel)
         FRT_EDGE_RISE: edge_hit = pin_sync & ~pin_prev;
         FRT_EDGE_FALL: edge_hit = ~pin_sync & pin_prev;
         FRT_EDGE_ANY: edge_hit = pin_sync ^ pin_prev;
         default: edge_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_prev <= 1'b0;
      end else begin
         pin_prev <= pin_sync;
      end
   end

   // Edge waits for the capture half-cycle, and longer if a high-byte read blocks it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pending <= 1'b0;
         event_pulse <= 1'b0;
      end else begin
         event_pulse <= 1'b0;
         if (pending && capture_phase && !hold) begin
            pending <= edge_hit & enable;
            event_pulse <= 1'b1;
         end else if (edge_hit && enable) begin
            pending <= 1'b1;
         end
      end
   end

   // Capture value is undefined at reset, so no reset term
   always_ff @(posedge clk) begin
      if (pending && capture_phase && !hold) begin
         capture <= count;
      end
   end
endmodule
`default_nettype wire

// [frt_timer_chk.sv]
// Checker for the free-running timer: counter, capture and request timing.
// Assumes it is bound into frt_timer and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module frt_timer_chk
   import frt_pkg::*;
#(
   parameter int W = FRT_CNT_W
) (
   // Inputs of the timer
   input wire logic I_CORE_CLK,
   input wire logic I_RST,
   input wire frt_edge_cfg_t I_EDGE_CFG,
   input wire logic I_CAPTURE4_SELECT,
   input wire logic [FRT_NUM_CAP-1:0] I_CAP_IRQ_ENABLE,
   input wire logic I_OVF_IRQ_ENABLE,
   input wire logic [FRT_NUM_CAP-1:0] I_CAP_FLAG_CLEAR,
   input wire logic [FRT_NUM_CMP-1:0] I_CMP_WRITE,
   input wire logic [FRT_NUM_CAP-1:0] I_CAP_HIGH_READ,
   input wire logic [7:0] I_PORT_A_PIN,
   // Outputs of the timer
   input wire logic [W-1:0] O_FREE_RUNNING_COUNT,
   input wire logic [FRT_NUM_CAP-1:0][W-1:0] O_CAPTURE,
   input wire logic [FRT_NUM_CMP-1:0][W-1:0] O_COMPARE,
   input wire logic [FRT_NUM_CAP-1:0] O_CAP_FLAG,
   input wire logic O_OVF_FLAG,
   input wire logic [FRT_NUM_CAP-1:0] O_CAP_IRQ,
   input wire logic O_OVF_IRQ,
   input wire logic [7:0] O_PORT_A_DATA_REG
);
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RST);
   // Selected rising edge on pin 0 with no high-byte read in the way
   sequence s_rise0;
      I_EDGE_CFG.edge_select_high_low_0 == FRT_EDGE_RISE && $rose(I_PORT_A_PIN[0])
         && !I_CAP_HIGH_READ[0];
   endsequence
   sequence s_pin0_high;
      $rose(I_PORT_A_PIN[0]) ##0 I_PORT_A_PIN[0] [*5];
   endsequence
   AST_COUNT_STEP: assert property (
      $changed(O_FREE_RUNNING_COUNT) |-> O_FREE_RUNNING_COUNT == $past(O_FREE_RUNNING_COUNT) + 1'b1)
      else $error("count moved by other than one");
   AST_OVF_SET: assert property (
      $past(O_FREE_RUNNING_COUNT) == W'(FRT_CNT_MAX)
      && O_FREE_RUNNING_COUNT == W'(FRT_CNT_RESET)
      |-> ##[0:2] O_OVF_FLAG) else $error("wrap without overflow flag");
   AST_OVF_IRQ: assert property (
      O_OVF_IRQ |-> $past(O_OVF_FLAG && I_OVF_IRQ_ENABLE)) else $error("overflow request unmasked");
   AST_CAP_IRQ: assert property (
      (O_CAP_IRQ & ~$past(O_CAP_FLAG & I_CAP_IRQ_ENABLE)) == 4'h0)
      else $error("capture request without flag and enable");
   AST_CAP_LATCH: assert property (
      $rose(O_CAP_FLAG[0]) |-> O_CAPTURE[0] == $past(O_FREE_RUNNING_COUNT))
      else $error("captured value differs from count");
   AST_CAP_STICKY: assert property (
      $fell(O_CAP_FLAG[0]) |-> $past(I_CAP_FLAG_CLEAR[0])) else $error("flag dropped without clear");
   AST_CAP_EDGE: assert property (
      s_rise0 |-> ##[2:8] O_CAP_FLAG[0]) else $error("rising edge not captured");
   AST_EDGE_OFF: assert property (
      (I_EDGE_CFG.edge_select_high_low_1 == FRT_EDGE_OFF) [*8] |-> !$rose(O_CAP_FLAG[1]))
      else $error("capture while disabled");
   AST_SHARED_WR: assert property (
      I_CAPTURE4_SELECT && I_CMP_WRITE[4] && I_EDGE_CFG.edge_select_high_low_3 == FRT_EDGE_OFF
      |=> $stable(O_COMPARE[4])) else $error("shared register written in capture mode");
   AST_PORT_LEVEL: assert property (
      s_pin0_high |-> O_PORT_A_DATA_REG[0]) else $error("pin level not readable");
endmodule
bind frt_timer frt_timer_chk #(.W(W)) frt_timer_chk_i (.I_CORE_CLK, .I_RST, .I_EDGE_CFG,
   .I_CAPTURE4_SELECT, .I_CAP_IRQ_ENABLE, .I_OVF_IRQ_ENABLE, .I_CAP_FLAG_CLEAR, .I_CMP_WRITE,
   .I_CAP_HIGH_READ, .I_PORT_A_PIN, .O_FREE_RUNNING_COUNT, .O_CAPTURE, .O_COMPARE, .O_CAP_FLAG,
   .O_OVF_FLAG, .O_CAP_IRQ, .O_OVF_IRQ, .O_PORT_A_DATA_REG);
`default_nettype wire

// [frt_event_src.sv]
// External event source that drives the port A pins.
// Assumes the caller changes levels just after a core clock edge.
`timescale 1ns/1ps
`default_nettype none
module frt_event_src (
   // Pin side
   output logic [7:0] o_pin
);
   initial o_pin = 8'h00;
   task automatic set_pin(input int p, input logic v);
      o_pin[p] = v;
   endtask
endmodule
`default_nettype wire

// [frt_timer_test.sv]
// Self-checking bench for the free-running timer.
// Assumes the checker is bound in and the event source drives port A.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("FAIL %s expected %h seen %h", what, exp, got); end end
module frt_timer_test
   import frt_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, c4sel = 1'b0, sdir = 1'b0, ovf_en = 1'b0, ovf_clr = 1'b0;
   logic [1:0] psel = 2'h0;
   frt_edge_cfg_t ecfg = 8'h00;
   logic [7:3] fmask = 5'h00, flvl = 5'h00;
   logic [3:0] cap_en = 4'h0, cap_clr = 4'h0, hread = 4'h0, capf, capirq;
   logic [4:0] cmp_en = 5'h00, cmp_clr = 5'h00, cmp_wr = 5'h00, cmp_ev = 5'h00, cmp_lvl = 5'h00;
   logic [4:0] cmpf, cmpirq;
   logic [15:0] wdata = 16'h0000, cnt;
   logic [7:0] pdata = 8'h00, pstb = 8'h00, pins, pdr;
   logic [3:0][15:0] cap;
   logic [4:0][15:0] cmp;
   logic ovff, ovfirq;
   logic ovff8, ovfirq8;
   logic [7:0] cnt8;
   logic [7:3] pout, poe;
   int n_mismatch = 0;
   int comparisons = 0;
   int divs[4] = '{1, 4, 8, 16};
   int n;
   always #2.5 clk = ~clk;
   frt_event_src frt_event_src_i (.o_pin(pins));
   frt_timer frt_timer_i (.I_CORE_CLK(clk), .I_RST(rst), .I_PRESCALE_SELECT(psel),
      .I_EDGE_CFG(ecfg), .I_CAPTURE4_SELECT(c4sel), .I_SHARED_PIN_DIRECTION(sdir),
      .I_FIRST_COMPARE_PIN_MASK(fmask), .I_FIRST_COMPARE_PIN_LEVEL(flvl),
      .I_CAP_IRQ_ENABLE(cap_en), .I_CMP_IRQ_ENABLE(cmp_en), .I_OVF_IRQ_ENABLE(ovf_en),
      .I_CAP_FLAG_CLEAR(cap_clr), .I_CMP_FLAG_CLEAR(cmp_clr), .I_OVF_FLAG_CLEAR(ovf_clr),
      .I_CMP_WRITE(cmp_wr), .I_CMP_WDATA(wdata), .I_CMP_MATCH_EVENT(cmp_ev),
      .I_CMP_PIN_LEVEL(cmp_lvl), .I_CAP_HIGH_READ(hread), .I_PORT_A_PIN(pins),
      .I_PORT_A_DATA_WRITE(pdata), .I_PORT_A_DATA_WSTB(pstb), .O_FREE_RUNNING_COUNT(cnt),
      .O_CAPTURE(cap), .O_COMPARE(cmp), .O_CAP_FLAG(capf), .O_CMP_FLAG(cmpf), .O_OVF_FLAG(ovff),
      .O_CAP_IRQ(capirq), .O_CMP_IRQ(cmpirq), .O_OVF_IRQ(ovfirq), .O_PORT_A_DATA_REG(pdr),
      .O_PORT_A_OUT(pout), .O_PORT_A_OE(poe));
   // Narrow counter so that the wrap and the overflow are reached within the run
   frt_timer #(.W(8)) frt_timer_ovf_i (.I_CORE_CLK(clk), .I_RST(rst), .I_PRESCALE_SELECT(2'h0),
      .I_EDGE_CFG(ecfg), .I_CAPTURE4_SELECT(c4sel), .I_SHARED_PIN_DIRECTION(sdir),
      .I_FIRST_COMPARE_PIN_MASK(fmask), .I_FIRST_COMPARE_PIN_LEVEL(flvl),
      .I_CAP_IRQ_ENABLE(cap_en), .I_CMP_IRQ_ENABLE(cmp_en), .I_OVF_IRQ_ENABLE(ovf_en),
      .I_CAP_FLAG_CLEAR(cap_clr), .I_CMP_FLAG_CLEAR(cmp_clr), .I_OVF_FLAG_CLEAR(ovf_clr),
      .I_CMP_WRITE(cmp_wr), .I_CMP_WDATA(wdata[7:0]), .I_CMP_MATCH_EVENT(cmp_ev),
      .I_CMP_PIN_LEVEL(cmp_lvl), .I_CAP_HIGH_READ(hread), .I_PORT_A_PIN(pins),
      .I_PORT_A_DATA_WRITE(pdata), .I_PORT_A_DATA_WSTB(pstb), .O_FREE_RUNNING_COUNT(cnt8),
      .O_CAPTURE(), .O_COMPARE(), .O_CAP_FLAG(), .O_CMP_FLAG(), .O_OVF_FLAG(ovff8),
      .O_CAP_IRQ(), .O_CMP_IRQ(), .O_OVF_IRQ(ovfirq8), .O_PORT_A_DATA_REG(),
      .O_PORT_A_OUT(), .O_PORT_A_OE());
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic do_reset();
      rst = 1'b1;
      step(3);
      rst = 1'b0;
      `CHECK("count", 16'h0000, cnt)
      `CHECK("flags", 4'h0, capf)
   endtask
   task automatic pin(input int p, input logic v);
      frt_event_src_i.set_pin(p, v);
      step(10);
   endtask
   task automatic clr_cap();
      cap_clr = 4'hf;
      step(1);
      cap_clr = 4'h0;
      step(1);
   endtask
   task automatic wr_cmp(input logic [15:0] d);
      wdata = d;
      cmp_wr = 5'h10;
      step(1);
      cmp_wr = 5'h00;
      step(1);
   endtask
   // Cycles until the count next changes
   task automatic gap(output int k);
      logic [15:0] c;
      c = cnt;
      k = 0;
      while (cnt === c && k < 100) begin
         step(1);
         k++;
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #50000;
      n_mismatch++;
      end_of_test();
   end
   initial begin
      do_reset();
      for (int k = 0; k < 4; k++) begin
         psel = 2'(k);
         gap(n);
         gap(n);
         gap(n);
         `CHECK("tick spacing", 2 * divs[k], n)
      end
      $display("test prescale done");
      for (int k = 0; k < 4; k++) begin
         ecfg.edge_select_high_low_1 = 2'(k);
         clr_cap();
         pin(1, 1'b1);
         `CHECK("rise flag", logic'(k[0]), capf[1])
         clr_cap();
         pin(1, 1'b0);
         `CHECK("fall flag", logic'(k[1]), capf[1])
      end
      $display("test edges done");
      ecfg = 8'h55;
      clr_cap();
      frt_event_src_i.set_pin(0, 1'b1);
      pin(2, 1'b1);
      `CHECK("same count", cap[0], cap[2])
      `CHECK("pin level", 1'b1, pdr[2])
      pin(0, 1'b0);
      clr_cap();
      hread = 4'h1;
      frt_event_src_i.set_pin(0, 1'b1);
      step(8);
      `CHECK("held capture", 1'b0, capf[0])
      hread = 4'h0;
      step(6);
      `CHECK("delayed capture", 1'b1, capf[0])
      cap_en = 4'h1;
      step(2);
      `CHECK("request on", 4'h1, capirq)
      cap_en = 4'h0;
      step(2);
      `CHECK("request off", 4'h0, capirq)
      $display("test capture done");
      cmp_lvl = 5'h10;
      pdata = 8'h70;
      pstb = 8'h78;
      cmp_ev = 5'h1f;
      step(1);
      pstb = 8'h00;
      cmp_ev = 5'h00;
      cmp_en = 5'h1f;
      step(2);
      `CHECK("compare flags", 5'h1f, cmpf)
      `CHECK("compare requests", 5'h1f, cmpirq)
      `CHECK("compare pins", 5'h01, pout)
      `CHECK("compare oe", 5'h0f, poe)
      `CHECK("latch view", 4'h7, pdr[7:4])
      cmp_clr = 5'h1f;
      cmp_en = 5'h00;
      step(1);
      cmp_clr = 5'h00;
      step(1);
      `CHECK("compare cleared", 5'h00, cmpf)
      `CHECK("compare requests off", 5'h00, cmpirq)
      cmp_lvl = 5'h00;
      $display("test compare done");
      wr_cmp(16'h1234);
      `CHECK("shared compare", 16'h1234, cmp[4])
      c4sel = 1'b1;
      ecfg.edge_select_high_low_3 = FRT_EDGE_OFF;
      wr_cmp(16'h5678);
      `CHECK("shared refused", 16'h1234, cmp[4])
      sdir = 1'b1;
      ecfg.edge_select_high_low_3 = FRT_EDGE_ANY;
      clr_cap();
      pdata = 8'h08;
      pstb = 8'h08;
      step(1);
      pstb = 8'h00;
      step(10);
      `CHECK("write capture", 1'b1, capf[3])
      fmask = 5'h10;
      flvl = 5'h10;
      step(3);
      `CHECK("first compare oe", 1'b1, poe[7])
      `CHECK("first compare out", 1'b1, pout[7])
      $display("test port done");
      ovf_clr = 1'b1;
      step(1);
      ovf_clr = 1'b0;
      n = 0;
      while (ovff8 !== 1'b1 && n < 600) begin
         step(1);
         n++;
      end
      `CHECK("overflow flag", 1'b1, ovff8)
      `CHECK("wrap count", 8'h00, cnt8)
      ovf_en = 1'b1;
      step(2);
      `CHECK("count after wrap", 8'h01, cnt8)
      `CHECK("overflow request", 1'b1, ovfirq8)
      ovf_clr = 1'b1;
      ovf_en = 1'b0;
      step(1);
      ovf_clr = 1'b0;
      `CHECK("overflow cleared", 1'b0, ovff8)
      `CHECK("overflow request off", 1'b0, ovfirq8)
      $display("test overflow done");
      do_reset();
      $display("test reset done");
      end_of_test();
   end
endmodule
`default_nettype wire
